/* logic/i2c_target_end.sv */
// Target end: bus address match, register pointer, single byte write and read.
`timescale 1ns/1ns
// Contract
// - Address is b10010 plus two strap pins.
// - Master first addresses with write direction.
// - Target acknowledges address and pointer bytes.
// - Master sends eight bit pointer, MSB first.
// - Pointer kept until reset or rewritten.
// - Master repeats start, readdresses with read.
// - Target shifts out pointed register, MSB first.
// - Master acknowledges data, then sends stop.
// - Repeated start may continue write or reads.
// - Data edges during clock high are conditions.
// - Data falling with clock high is start.
// - Target drives data only for ack, read.
// - Repeated start: data high, clock high, fall.
// - Works at 100 kHz and 400 kHz.
// - Write byte is stored and acknowledged.
module i2c_target_end import i2c_port_pkg::*; (
  // Clock and reset.
  input logic clk,
  input logic sys_rst,
  // Bus side.
  i2c_link_if.target link,
  // Address strap pins.
  input logic addr_select_hi_pin,
  input logic addr_select_lo_pin,
  // Register file side.
  output logic [7:0] reg_ptr,
  output logic reg_wr_stb,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_stb,
  input logic [7:0] reg_rd_data
);

  typedef struct packed {
    t_state_t st;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic hi_s1;
    logic hi_s2;
    logic lo_s1;
    logic lo_s2;
    logic scl_f;
    logic sda_f;
    logic scl_fp;
    logic sda_fp;
    logic [FILT_W-1:0] scl_c;
    logic [FILT_W-1:0] sda_c;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic [7:0] ptr;
    logic [7:0] wdat;
    logic wr_stb;
    logic rd_stb;
    logic sda_oe;
    logic sda_o;
  } tgt_t;

  // Idle bus lines are high, so the filters start high to avoid a false start.
  localparam tgt_t TGT_RST = '{st: T_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, sda_s1: 1'b1,
    sda_s2: 1'b1, scl_f: 1'b1, sda_f: 1'b1, scl_fp: 1'b1, sda_fp: 1'b1, default: '0};

  tgt_t r_r;
  tgt_t r_nxt;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [6:0] my_addr;

  // A level change passes only after it has held for the whole filter time.
  function automatic logic [FILT_W:0] filt_step(input logic s, input logic f,
                                               input logic [FILT_W-1:0] c);
    if (s == f) begin
      return {f, {FILT_W{1'b0}}};
    end
    if (c == FILT_LAST) begin
      return {s, {FILT_W{1'b0}}};
    end
    return {f, c + 1'b1};
  endfunction

  // Bus events from the filtered lines.
  assign scl_rise = ~r_r.scl_fp & r_r.scl_f;
  assign scl_fall = r_r.scl_fp & ~r_r.scl_f;
  assign start_cond = r_r.scl_f & r_r.sda_fp & ~r_r.sda_f;
  assign stop_cond = r_r.scl_f & ~r_r.sda_fp & r_r.sda_f;
  assign my_addr = {ADDR_FIXED, r_r.hi_s2, r_r.lo_s2};

  // Next state of the whole target.
  always_comb begin
    r_nxt = r_r;
    // Two flops per outside line, then the filter reads only the second.
    r_nxt.scl_s1 = link.scl;
    r_nxt.scl_s2 = r_r.scl_s1;
    r_nxt.sda_s1 = link.sda;
    r_nxt.sda_s2 = r_r.sda_s1;
    r_nxt.hi_s1 = addr_select_hi_pin;
    r_nxt.hi_s2 = r_r.hi_s1;
    r_nxt.lo_s1 = addr_select_lo_pin;
    r_nxt.lo_s2 = r_r.lo_s1;
    {r_nxt.scl_f, r_nxt.scl_c} = filt_step(r_r.scl_s2, r_r.scl_f, r_r.scl_c);
    {r_nxt.sda_f, r_nxt.sda_c} = filt_step(r_r.sda_s2, r_r.sda_f, r_r.sda_c);
    r_nxt.scl_fp = r_r.scl_f;
    r_nxt.sda_fp = r_r.sda_f;
    r_nxt.wr_stb = 1'b0;
    r_nxt.rd_stb = 1'b0;
    r_nxt.sda_o = 1'b0;
    if (start_cond) begin
      // A start or repeated start always restarts address decoding.
      r_nxt.st = T_ADDR;
      r_nxt.cnt = '0;
      r_nxt.sda_oe = 1'b0;
    end else if (stop_cond) begin
      r_nxt.st = T_IDLE;
      r_nxt.cnt = '0;
      r_nxt.sda_oe = 1'b0;
    end else begin
      unique case (r_r.st)
        T_IDLE, T_IGNORE: begin
          // Wait for a start; a foreign transfer is never answered.
          r_nxt.sda_oe = 1'b0;
        end
        T_ADDR, T_PTR, T_WDATA: begin
          if (scl_rise && r_r.cnt != BYTE_BITS) begin
            // Bits are taken MSB first while the clock is high.
            r_nxt.sh = {r_r.sh[6:0], r_r.sda_f};
            r_nxt.cnt = r_r.cnt + 4'h1;
          end else if (scl_fall && r_r.cnt == BYTE_BITS) begin
            r_nxt.cnt = '0;
            r_nxt.sda_oe = 1'b1;
            if (r_r.st == T_ADDR) begin
              if (r_r.sh[7:1] == my_addr) begin
                r_nxt.rw = r_r.sh[0];
                r_nxt.st = T_ACK_ADDR;
              end else begin
                r_nxt.sda_oe = 1'b0;
                r_nxt.st = T_IGNORE;
              end
            end else if (r_r.st == T_PTR) begin
              r_nxt.ptr = r_r.sh;
              r_nxt.st = T_ACK_PTR;
            end else begin
              r_nxt.wdat = r_r.sh;
              r_nxt.wr_stb = 1'b1;
              r_nxt.st = T_ACK_WDATA;
            end
          end
        end
        T_ACK_ADDR, T_ACK_PTR, T_ACK_WDATA: begin
          // The ack is held through one full clock pulse and dropped on its fall.
          if (scl_fall) begin
            r_nxt.sda_oe = 1'b0;
            if (r_r.st == T_ACK_ADDR && r_r.rw) begin
              r_nxt.sh = reg_rd_data;
              r_nxt.rd_stb = 1'b1;
              r_nxt.sda_oe = ~reg_rd_data[7];
              r_nxt.st = T_RDATA;
            end else if (r_r.st == T_ACK_ADDR) begin
              r_nxt.st = T_PTR;
            end else if (r_r.st == T_ACK_PTR) begin
              r_nxt.st = T_WDATA;
            end else begin
              r_nxt.st = T_IGNORE;
            end
          end
        end
        T_RDATA: begin
          // Each bit is put out on a clock fall so it is stable while high.
          if (scl_rise) begin
            r_nxt.cnt = r_r.cnt + 4'h1;
          end else if (scl_fall) begin
            if (r_r.cnt == BYTE_BITS) begin
              r_nxt.sda_oe = 1'b0;
              r_nxt.cnt = '0;
              r_nxt.st = T_RACK;
            end else begin
              r_nxt.sda_oe = ~r_r.sh[6];
              r_nxt.sh = {r_r.sh[6:0], 1'b0};
            end
          end
        end
        T_RACK: begin
          // The master answers this slot; only one byte is served per address.
          if (scl_fall) begin
            r_nxt.st = T_IGNORE;
          end
        end
        default: begin
          r_nxt.st = T_IDLE;
          r_nxt.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_r <= TGT_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs straight from the state register; the line is only ever pulled low.
  assign link.t_sda_oe = r_r.sda_oe;
  assign link.t_sda_o = r_r.sda_o;
  assign reg_ptr = r_r.ptr;
  assign reg_wr_stb = r_r.wr_stb;
  assign reg_wr_data = r_r.wdat;
  assign reg_rd_stb = r_r.rd_stb;
endmodule

/* logic/i2c_port_pkg.sv */
// Shared constants and types for both ends of the two-wire register port.
package i2c_port_pkg;
  // System clock rate, in kHz.
  localparam int CLK_KHZ = 125000;
  // Upper five bits of the target's bus address.
  localparam logic [4:0] ADDR_FIXED = 5'h12;
  // Glitch filter: least time a line must hold a new level, and its cycle count.
  localparam int FILT_NS = 50;
  localparam int FILT_CYC = (FILT_NS * CLK_KHZ + 999999) / 1000000;
  localparam int FILT_W = 3;
  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYC - 1);
  // Bus rates in kHz.
  localparam int BUS_KHZ_STD = 100;
  localparam int BUS_KHZ_FAST = 400;
  // Bits in one byte, as a bit counter value.
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Quarter bit period counter width.
  localparam int QTR_W = 10;

  // Quarter of a bus bit period in clock cycles, rounded up so the rate never exceeds the bus rate.
  function automatic int qtr_cycles(input int bus_khz);
    return (CLK_KHZ + 4 * bus_khz - 1) / (4 * bus_khz);
  endfunction

  // Target end states.
  typedef enum logic [9:0] {
    T_IDLE = 10'h001, T_ADDR = 10'h002, T_ACK_ADDR = 10'h004, T_PTR = 10'h008,
    T_ACK_PTR = 10'h010, T_WDATA = 10'h020, T_ACK_WDATA = 10'h040, T_RDATA = 10'h080,
    T_RACK = 10'h100, T_IGNORE = 10'h200
  } t_state_t;

  // Master end states.
  typedef enum logic [1:0] {M_IDLE = 2'h1, M_RUN = 2'h2} m_state_t;

  // Master command kinds.
  typedef enum logic [1:0] {K_WRITE = 2'h0, K_READ = 2'h1, K_REREAD = 2'h2} cmd_kind_t;

  // Master bus operations.
  typedef enum logic [2:0] {
    OP_START = 3'h0, OP_ADDR_W = 3'h1, OP_PTR = 3'h2, OP_DATA = 3'h3,
    OP_ADDR_R = 3'h4, OP_RX = 3'h5, OP_STOP = 3'h6, OP_DONE = 3'h7
  } op_t;
endpackage

/* logic/i2c_link_if.sv */
// Two-wire link joining the bus master end and the register target end.
`timescale 1ns/1ns
interface i2c_link_if;
  // Master drives the clock line; both ends may pull the data line low.
  logic scl_o;
  logic scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic t_sda_o;
  logic t_sda_oe;
  logic scl;
  logic sda;

  // Resolved line levels; a released line floats high through its pull-up.
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = ((m_sda_oe & ~m_sda_o) | (t_sda_oe & ~t_sda_o)) ? 1'b0 : 1'b1;

  modport target (input scl, input sda, output t_sda_o, output t_sda_oe);
  modport master (input sda, output scl_o, output scl_oe, output m_sda_o, output m_sda_oe);
endinterface

/* logic/i2c_master_end.sv */
// Master end: turns user commands into write, read and reread bus transfers.
`timescale 1ns/1ns
module i2c_master_end import i2c_port_pkg::*; #(
  parameter int BUS_KHZ = BUS_KHZ_FAST
) (
  // Clock and reset.
  input logic clk,
  input logic sys_rst,
  // Bus side.
  i2c_link_if.master link,
  // Command side.
  input logic cmd_valid,
  output logic cmd_ready,
  input cmd_kind_t cmd_kind,
  input logic cmd_hold,
  input logic [6:0] cmd_dev,
  input logic [7:0] cmd_ptr,
  input logic [7:0] cmd_data,
  // Answer side.
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);

  localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(qtr_cycles(BUS_KHZ) - 1);

  typedef struct packed {
    m_state_t st;
    op_t op;
    cmd_kind_t kind;
    logic hold;
    logic [2:0] idx;
    logic [QTR_W-1:0] qc;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [6:0] dev;
    logic [7:0] ptr;
    logic [7:0] data;
    logic nack;
    logic sda_s1;
    logic sda_s2;
    logic scl_o;
    logic scl_oe;
    logic sda_oe;
    logic sda_o;
    logic rdy;
    logic rsp;
    logic [7:0] rdat;
    logic rnack;
  } mst_t;

  localparam mst_t MST_RST = '{st: M_IDLE, op: OP_DONE, kind: K_WRITE, sda_s1: 1'b1,
    sda_s2: 1'b1, scl_o: 1'b1, scl_oe: 1'b1, rdy: 1'b1, default: '0};

  mst_t r_r;
  mst_t r_nxt;
  op_t nop;
  logic tick;

  // Operation sequence of each command kind.
  function automatic op_t op_at(input cmd_kind_t k, input logic [2:0] i);
    op_t w[8];
    op_t rd[8];
    op_t rr[8];
    w = '{OP_START, OP_ADDR_W, OP_PTR, OP_DATA, OP_STOP, OP_DONE, OP_DONE, OP_DONE};
    rd = '{OP_START, OP_ADDR_W, OP_PTR, OP_START, OP_ADDR_R, OP_RX, OP_STOP, OP_DONE};
    rr = '{OP_START, OP_ADDR_R, OP_RX, OP_STOP, OP_DONE, OP_DONE, OP_DONE, OP_DONE};
    if (k == K_WRITE) begin
      return w[i];
    end
    if (k == K_READ) begin
      return rd[i];
    end
    return rr[i];
  endfunction

  assign tick = (r_r.qc == QTR_LAST);

  // Next operation: a refused byte forces a stop; a held bus skips the stop.
  always_comb begin
    nop = op_at(r_r.kind, r_r.idx + 3'h1);
    if (r_r.nack && r_r.op != OP_STOP) begin
      nop = OP_STOP;
    end else if (r_r.nack || (nop == OP_STOP && r_r.hold)) begin
      nop = OP_DONE;
    end
  end

  // Next state of the whole master.
  always_comb begin
    r_nxt = r_r;
    r_nxt.sda_s1 = link.sda;
    r_nxt.sda_s2 = r_r.sda_s1;
    r_nxt.rsp = 1'b0;
    r_nxt.sda_o = 1'b0;
    r_nxt.qc = tick ? '0 : r_r.qc + 1'b1;
    unique case (r_r.st)
      M_IDLE: begin
        r_nxt.qc = '0;
        if (cmd_valid && r_r.rdy) begin
          r_nxt = '{st: M_RUN, op: OP_START, kind: cmd_kind, hold: cmd_hold, dev: cmd_dev,
            ptr: cmd_ptr, data: cmd_data, sda_s1: r_nxt.sda_s1, sda_s2: r_nxt.sda_s2,
            scl_o: r_r.scl_o, scl_oe: 1'b1, default: '0};
        end
      end
      M_RUN: begin
        if (tick) begin
          r_nxt.q = r_r.q + 2'h1;
          if (r_r.op == OP_START || r_r.op == OP_STOP) begin
            // Data moves only while the clock is high, forming the condition.
            unique case (r_r.q)
              2'h0: r_nxt.scl_o = 1'b1;
              2'h1: r_nxt.sda_oe = (r_r.op == OP_START);
              2'h2: r_nxt.scl_o = (r_r.op == OP_STOP);
              2'h3: r_nxt.op = nop;
            endcase
          end else begin
            unique case (r_r.q)
              2'h0: r_nxt.scl_o = 1'b1;
              2'h1: begin
                // Sample mid high; the ninth bit of a sent byte is the answer.
                if (r_r.bitn == BYTE_BITS) begin
                  r_nxt.nack = (r_r.op != OP_RX) & r_r.sda_s2;
                end else if (r_r.op == OP_RX) begin
                  r_nxt.sh = {r_r.sh[6:0], r_r.sda_s2};
                end
              end
              2'h2: r_nxt.scl_o = 1'b0;
              2'h3: begin
                r_nxt.bitn = r_r.bitn + 4'h1;
                if (r_r.bitn == BYTE_BITS) begin
                  r_nxt.op = nop;
                  r_nxt.rdat = r_r.sh;
                end else if (r_r.bitn == BYTE_BITS - 4'h1) begin
                  r_nxt.sda_oe = (r_r.op == OP_RX);
                end else begin
                  r_nxt.sh = (r_r.op == OP_RX) ? r_r.sh : {r_r.sh[6:0], 1'b0};
                  r_nxt.sda_oe = (r_r.op != OP_RX) & ~r_r.sh[6];
                end
              end
            endcase
          end
          // Entry action of the next operation, at the start of its first quarter.
          if (r_r.q == 2'h3 && r_nxt.op != r_r.op || r_r.q == 2'h3 && r_r.bitn == BYTE_BITS) begin
            r_nxt.idx = r_r.idx + 3'h1;
            r_nxt.bitn = '0;
            unique case (r_nxt.op)
              OP_ADDR_W: r_nxt.sh = {r_r.dev, 1'b0};
              OP_ADDR_R: r_nxt.sh = {r_r.dev, 1'b1};
              OP_PTR: r_nxt.sh = r_r.ptr;
              OP_DATA: r_nxt.sh = r_r.data;
              default: r_nxt.sh = '0;
            endcase
            r_nxt.sda_oe = (r_nxt.op == OP_STOP) ? 1'b1 :
                           (r_nxt.op == OP_START || r_nxt.op == OP_RX) ? 1'b0 : ~r_nxt.sh[7];
            if (r_nxt.op == OP_DONE) begin
              r_nxt.st = M_IDLE;
              r_nxt.rdy = 1'b1;
              r_nxt.rsp = 1'b1;
              r_nxt.rnack = r_r.nack | (r_r.bitn == BYTE_BITS && r_r.op != OP_RX && r_nxt.nack);
              r_nxt.sda_oe = r_r.hold & ~r_r.nack;
            end
          end
        end
      end
      default: r_nxt = MST_RST;
    endcase
  end

  // State register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_r <= MST_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs straight from the state register; only this end drives the clock.
  assign link.scl_o = r_r.scl_o;
  assign link.scl_oe = r_r.scl_oe;
  assign link.m_sda_o = r_r.sda_o;
  assign link.m_sda_oe = r_r.sda_oe;
  assign cmd_ready = r_r.rdy;
  assign rsp_valid = r_r.rsp;
  assign rsp_data = r_r.rdat;
  assign rsp_nack = r_r.rnack;
endmodule

/* sim/i2c_link_chk.sv */
// Concurrent checks on the two-wire link between the master end and the target end.
`timescale 1ns/1ns
module i2c_link_chk import i2c_port_pkg::*; #(
  parameter int BUS_KHZ = BUS_KHZ_FAST
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Link drivers and resolved lines.
  input wire logic scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic t_sda_o,
  input wire logic t_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // Quarter bit time; no clock phase may be shorter, or the bus rate is exceeded.
  localparam int QTR = (CLK_KHZ + 4 * BUS_KHZ - 1) / (4 * BUS_KHZ);
  logic [15:0] low_cnt_r;
  logic [15:0] high_cnt_r;

  // Phase length counters; they saturate so that a long idle bus cannot wrap them.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_cnt_r <= 16'h0000;
      high_cnt_r <= 16'h0000;
    end else begin
      low_cnt_r <= scl ? 16'h0000 : low_cnt_r + {15'h0000, low_cnt_r != 16'hffff};
      high_cnt_r <= !scl ? 16'h0000 : high_cnt_r + {15'h0000, high_cnt_r != 16'hffff};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Only the master drives the clock line, and it never lets go of it.
  scl_driven_a: assert property (scl_oe)
    else $error("clock line not driven by the master");
  tgt_open_drain_a: assert property (t_sda_oe |-> !t_sda_o)
    else $error("target drives the data line high");
  mst_open_drain_a: assert property (m_sda_oe |-> !m_sda_o)
    else $error("master drives the data line high");
  // The target moves the data line only shortly after a clock fall.
  tgt_edge_time_a: assert property ($changed(t_sda_oe) |-> !scl && low_cnt_r <= 16'h0010)
    else $error("target data edge outside the clock low window");
  tgt_hold_high_a: assert property (scl && $past(scl) |-> $stable(t_sda_oe))
    else $error("target data changed while the clock was high");
  start_by_master_a: assert property (scl && $past(scl) && $fell(sda) |-> m_sda_oe && !t_sda_oe)
    else $error("start condition not made by the master");
  low_phase_a: assert property (scl && !$past(scl) |-> low_cnt_r >= QTR)
    else $error("clock low phase too short");
  high_phase_a: assert property (!scl && $past(scl) |-> high_cnt_r >= QTR)
    else $error("clock high phase too short");
endmodule

/* sim/i2c_slave_register_read_port_tb.sv */
// Self-checking bench: master end and target end joined over the two-wire link.
`timescale 1ns/1ns
module i2c_slave_register_read_port_tb import i2c_port_pkg::*;;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] strap = 2'h3;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  cmd_kind_t cmd_kind = K_WRITE;
  logic cmd_hold = 1'b0;
  logic [6:0] cmd_dev = 7'h00;
  logic [7:0] cmd_ptr = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_nack;
  logic [7:0] reg_ptr;
  logic reg_wr_stb;
  logic [7:0] reg_wr_data;
  logic reg_rd_stb;
  logic [7:0] regs [256];
  int error_cnt = 0;
  int n_tests = 0;
  int rd_cnt = 0;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic [7:0] mon_sh = 8'h00;
  logic [3:0] mon_cnt = 4'h8;

  // Clock at 125 MHz.
  always #4 clk = ~clk;

  i2c_link_if link ();

  i2c_master_end #(.BUS_KHZ(BUS_KHZ_FAST)) u_i2c_master_end (
    .clk(clk), .sys_rst(sys_rst), .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_kind(cmd_kind), .cmd_hold(cmd_hold), .cmd_dev(cmd_dev), .cmd_ptr(cmd_ptr),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack)
  );

  i2c_target_end u_i2c_target_end (
    .clk(clk), .sys_rst(sys_rst), .link(link), .addr_select_hi_pin(strap[1]),
    .addr_select_lo_pin(strap[0]), .reg_ptr(reg_ptr), .reg_wr_stb(reg_wr_stb),
    .reg_wr_data(reg_wr_data), .reg_rd_stb(reg_rd_stb), .reg_rd_data(regs[reg_ptr])
  );

  i2c_link_chk #(.BUS_KHZ(BUS_KHZ_FAST)) u_i2c_link_chk (
    .clk(clk), .sys_rst(sys_rst), .scl_oe(link.scl_oe), .m_sda_o(link.m_sda_o),
    .m_sda_oe(link.m_sda_oe), .t_sda_o(link.t_sda_o), .t_sda_oe(link.t_sda_oe),
    .scl(link.scl), .sda(link.sda)
  );

  // Register file behind the target; read strobes are counted to catch extra reads.
  always @(posedge clk) begin
    if (reg_wr_stb) regs[reg_ptr] <= reg_wr_data;
    if (reg_rd_stb) rd_cnt <= rd_cnt + 1;
  end

  // Wire monitor: keeps the first byte after each start, MSB first.
  always @(posedge clk) begin
    scl_q <= link.scl;
    sda_q <= link.sda;
    if (scl_q && link.scl && sda_q && !link.sda) begin
      mon_cnt <= 4'h0;
    end else if (!scl_q && link.scl && mon_cnt < 4'h8) begin
      mon_sh <= {mon_sh[6:0], link.sda};
      mon_cnt <= mon_cnt + 4'h1;
    end
  end

  task automatic stop_test;
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One command to the master, then a bounded wait for its answer pulse.
  task automatic xfer(input cmd_kind_t k, input logic h, input logic [6:0] dev,
                      input logic [7:0] p, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_hold = h;
    cmd_dev = dev;
    cmd_ptr = p;
    cmd_data = d;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40000) begin
      error_cnt++;
      $display("mismatch at %0t ns: no answer from the master", $time);
      stop_test();
    end
  endtask

  // Main sequence: write, held read, chained reread, foreign address, chained write and read.
  initial begin
    logic [6:0] dev;
    for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'ha5;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    check(reg_ptr, 8'h00, "pointer after reset");
    check({7'h00, cmd_ready}, 8'h01, "ready after reset");
    dev = {ADDR_FIXED, 2'h3};
    xfer(K_WRITE, 1'b0, dev, 8'h6d, 8'h92);
    check({7'h00, rsp_nack}, 8'h00, "write acknowledged");
    check(regs[8'h6d], 8'h92, "written byte");
    check(reg_ptr, 8'h6d, "pointer loaded");
    check(mon_sh, {dev, 1'b0}, "address byte on wire");
    check({6'h00, link.scl, link.sda}, 8'h03, "bus released after stop");
    xfer(K_READ, 1'b1, dev, 8'h6d, 8'h00);
    check({7'h00, rsp_nack}, 8'h00, "read acknowledged");
    check(rsp_data, 8'h92, "read byte");
    check(mon_sh, {dev, 1'b1}, "read address byte on wire");
    check(8'(rd_cnt), 8'h01, "one read strobe");
    xfer(K_REREAD, 1'b0, dev, 8'h00, 8'h00);
    check(rsp_data, 8'h92, "reread byte");
    check(8'(rd_cnt), 8'h02, "second read strobe");
    strap = 2'h1;
    repeat (4) @(negedge clk);
    xfer(K_WRITE, 1'b0, dev, 8'hff, 8'hc3);
    check({7'h00, rsp_nack}, 8'h01, "foreign address refused");
    check(regs[8'hff], 8'h5a, "foreign write ignored");
    check(reg_ptr, 8'h6d, "pointer kept");
    dev = {ADDR_FIXED, 2'h1};
    xfer(K_WRITE, 1'b1, dev, 8'hff, 8'hc3);
    check({7'h00, rsp_nack}, 8'h00, "new strap address acknowledged");
    check(regs[8'hff], 8'hc3, "top register written");
    xfer(K_READ, 1'b0, dev, 8'h6d, 8'h00);
    check(rsp_data, 8'h92, "read after chained write");
    check(reg_ptr, 8'h6d, "pointer rewritten");
    // A reset in mid-run on an idle bus must clear the stored pointer.
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    check(reg_ptr, 8'h00, "pointer cleared by reset");
    // Held reread, so the following write must begin with a repeated start.
    xfer(K_REREAD, 1'b1, dev, 8'h00, 8'h00);
    check(rsp_data, 8'ha5, "reread after reset");
    xfer(K_WRITE, 1'b0, dev, 8'h10, 8'h3c);
    check({7'h00, rsp_nack}, 8'h00, "chained write acknowledged");
    check(regs[8'h10], 8'h3c, "write after repeated start");
    check(reg_ptr, 8'h10, "pointer from chained write");
    stop_test();
  end
endmodule
